// ### rtl/fcpc_pkg.sv
// constants and carrier types for the flash configuration and protection block
package fcpc_pkg;

	// ==========================================
	// address map
	localparam logic [31:0] FCPC_REG_BASE = 32'h00d00000;
	localparam logic [31:0] FCPC_REG_MASK = 32'hffffffe0;
	localparam logic [31:0] FCPC_MCR_ADDR = 32'h00d00000;
	localparam logic [31:0] FCPC_MTR_ADDR = 32'h00d00004;
	localparam logic [31:0] FCPC_HVC_ADDR = 32'h00d00008;
	localparam logic [31:0] FCPC_ARRAY_BASE = 32'h00000000;
	localparam logic [31:0] FCPC_ARRAY_MASK = 32'hfffe0000;
	localparam int FCPC_BLK_LSB = 14;
	localparam int FCPC_ARR_ADDR_W = 17;
	localparam int FCPC_SHADOW_ADDR_W = 8;

	// ==========================================
	// reset values and page buffer masks
	localparam logic [7:0] FCPC_SUPER_RST = 8'hff;
	localparam logic [7:0] FCPC_DATA_RST = 8'h00;
	localparam logic [7:0] FCPC_PROT_RST = 8'hff;
	localparam logic [7:0] FCPC_SHADOW_MASK = 8'h01;
	localparam logic [7:0] FCPC_ALL_BLOCKS = 8'hff;

	// ==========================================
	// register layouts, msb first
	typedef struct packed {
		logic lowPowerStop;
		logic debugUnlock;
		logic zero29;
		logic emulationEnable;
		logic shadowRowSelect;
		logic writeLock;
		logic arrayDisable;
		logic spare24;
		logic [7:0] supervisorMap;
		logic [7:0] dataMap;
		logic [7:0] protectMap;
	} fcpc_mcr_type;

	typedef struct packed {
		logic [19:0] zeroHi;
		logic negativeRange;
		logic [2:0] pulseLevelSelect;
		logic zero7;
		logic zero6;
		logic gateDrainSelect;
		logic [4:0] zeroLo;
	} fcpc_mtr_type;

	typedef struct packed {
		logic highVoltageStatus;
		logic zero30;
		logic [2:0] clockRange;
		logic zero26;
		logic [1:0] pulseExp;
		logic zero23;
		logic [6:0] pulseMult;
		logic [7:0] blockSelect;
		logic [1:0] zero7to6;
		logic one5;
		logic [1:0] zero4to3;
		logic erase;
		logic sequenceEnable;
		logic highVoltageEnable;
	} fcpc_hvc_type;

	// ==========================================
	// bus and array carriers, sequencer states
	typedef struct packed {
		logic valid;
		logic write;
		logic supervisor;
		logic dataSpace;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fcpc_busreq_type;

	typedef struct packed {
		logic ack;
		logic transferErr;
		logic dataErr;
		logic rdataOe;
		logic [31:0] rdata;
	} fcpc_busrsp_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic shadow;
		logic emulate;
		logic [FCPC_ARR_ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} fcpc_arrreq_type;

	typedef enum logic [1:0] {
		FCPC_IDLE = 2'b00,
		FCPC_ISSUE = 2'b01,
		FCPC_WAIT = 2'b10
	} fcpc_state_type;

endpackage

// ### rtl/fcpc_hv_ctrl.sv
// high-voltage control register: sequence enable, erase, block select, pulse timing fields
module fcpc_hv_ctrl
	import fcpc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstSyncN,
	input wire logic clkEn,
	// register write port
	input wire logic wrEn,
	input wire logic [31:0] wdata,
	// pulse engine status
	input wire logic highVoltageStatus,
	// register state
	output fcpc_hvc_type hvcReg,
	output logic seqStart
);

	// ==========================================
	// decode
	fcpc_hvc_type wrVal;
	logic seqEnWritable;
	logic seqEnRise;
	assign wrVal = fcpc_hvc_type'(wdata);
	assign seqEnWritable = !highVoltageStatus;
	assign seqEnRise = wrEn && seqEnWritable && wrVal.sequenceEnable &&
		!hvcReg.sequenceEnable;

	logic seqEn_ff, nxt_seqEn;
	logic hvEn_ff, nxt_hvEn;
	logic erase_ff, nxt_erase;
	logic [7:0] blk_ff, nxt_blk;
	logic [2:0] range_ff, nxt_range;
	logic [1:0] pexp_ff, nxt_pexp;
	logic [6:0] pmul_ff, nxt_pmul;
	logic start_ff;

	assign nxt_seqEn = (wrEn && seqEnWritable) ? wrVal.sequenceEnable : seqEn_ff;
	assign nxt_hvEn = wrEn ? wrVal.highVoltageEnable : hvEn_ff;
	assign nxt_erase = (wrEn && !seqEn_ff) ? wrVal.erase : erase_ff;
	assign nxt_blk = (wrEn && !seqEn_ff) ? wrVal.blockSelect : blk_ff;
	assign nxt_range = wrEn ? wrVal.clockRange : range_ff;
	assign nxt_pexp = wrEn ? wrVal.pulseExp : pexp_ff;
	assign nxt_pmul = wrEn ? wrVal.pulseMult : pmul_ff;

	// ==========================================
	// state
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			seqEn_ff <= 1'b0;
			hvEn_ff <= 1'b0;
			erase_ff <= 1'b0;
			blk_ff <= 8'h00;
			range_ff <= 3'h0;
			pexp_ff <= 2'h0;
			pmul_ff <= 7'h00;
			start_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			seqEn_ff <= nxt_seqEn;
			hvEn_ff <= nxt_hvEn;
			erase_ff <= nxt_erase;
			blk_ff <= nxt_blk;
			range_ff <= nxt_range;
			pexp_ff <= nxt_pexp;
			pmul_ff <= nxt_pmul;
			start_ff <= seqEnRise;
		end
	end

	assign seqStart = start_ff;

	// status bit mirrors the pulse engine directly
	always_comb
	begin
		hvcReg = '0;
		hvcReg.highVoltageStatus = highVoltageStatus;
		hvcReg.clockRange = range_ff;
		hvcReg.pulseExp = pexp_ff;
		hvcReg.pulseMult = pmul_ff;
		hvcReg.blockSelect = blk_ff;
		hvcReg.one5 = 1'b1;
		hvcReg.erase = erase_ff;
		hvcReg.sequenceEnable = seqEn_ff;
		hvcReg.highVoltageEnable = hvEn_ff;
	end

endmodule

// ### rtl/fcpc_top.sv
// flash configuration, access mapping and protection logic with its register port
// Contract
// - in stop mode only config register served; other registers bus error, array accesses unanswered; sequence enable blocks writes
// - debug-unlock bit lets the lock bit be rewritten in debug mode; write it first
// - emulation bit writable only while lock and array-disable bits are both set
// - emulation reads end without driving data, same timing; writes unchanged
// - shadow select ignores writes while erase clear and sequence enable set
// - shadow reads use low address bits only; registers unaffected
// - shadow mode lets only block 0 page buffer program; others get no voltage
// - lock resets to 0, set once normally, writable in debug mode
// - while locked, map field writes end normally and change nothing
// - the write that sets the lock still updates the map fields
// - array-disable ignores writes under sequence enable; when set array is silent
// - array-disable reset value is sampled from the strap pin
// - spare bit 24 stores and reads back, no effect
// - supervisor map, reset all ones, user access to marked block gives data error
// - data map, reset zero, program access to marked block gives data error
// - protect map resets to ones; writes ignored when locked or sequence enabled
// - protected blocks keep interlocks but receive no program or erase voltage
// - negative range writable while status clear; inactive while drain selected
// - gate mode codes 100..111 pick four pump levels; 0xx reserved
// - sequence enable rising from 0 to 1 starts a sequence
// - high-voltage status is 1 during pulse and recovery
module fcpc_top
	import fcpc_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	// chip straps and modes
	input wire logic configStrapPin,
	input wire logic debugMode,
	// processor bus
	input fcpc_busreq_type busReq,
	output logic busReady,
	output fcpc_busrsp_type busRsp,
	// array core
	output fcpc_arrreq_type arrReq,
	input wire logic arrAck,
	input wire logic [31:0] arrRdata,
	// program and erase engine
	input wire logic highVoltageStatus,
	output logic seqStart,
	output fcpc_hvc_type hvcReg,
	output logic [7:0] pageBufEnable,
	output logic [7:0] hvBlockEnable,
	output logic lowPowerStop,
	// negative pump
	output logic pumpLevelValid,
	output logic [1:0] pumpLevel,
	output logic negLowRange
);

	// ==========================================
	// reset release
	logic rstMeta_ff;
	logic rstSyncN;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rstMeta_ff <= 1'b0;
			rstSyncN <= 1'b0;
		end
		else
		begin
			rstMeta_ff <= 1'b1;
			rstSyncN <= rstMeta_ff;
		end
	end

	// ==========================================
	// address decode
	fcpc_state_type state_ff, nxt_state;
	fcpc_mcr_type mcr_ff, nxt_mcr;
	fcpc_mtr_type mtr_ff, nxt_mtr;
	fcpc_mcr_type wrMcr;
	fcpc_mtr_type wrMtr;
	logic strapDone_ff;

	wire take = busReq.valid && (state_ff == FCPC_IDLE) && strapDone_ff;
	wire regHit = (busReq.addr & FCPC_REG_MASK) == FCPC_REG_BASE;
	wire arrHit = (busReq.addr & FCPC_ARRAY_MASK) == FCPC_ARRAY_BASE;
	wire mcrSel = regHit && (busReq.addr[4:2] == FCPC_MCR_ADDR[4:2]);
	wire mtrSel = regHit && (busReq.addr[4:2] == FCPC_MTR_ADDR[4:2]);
	wire hvcSel = regHit && (busReq.addr[4:2] == FCPC_HVC_ADDR[4:2]);
	wire stopped = mcr_ff.lowPowerStop;
	wire seqOn = hvcReg.sequenceEnable;

	// register access results
	wire regOk = mcrSel || (!stopped && (mtrSel || hvcSel));
	wire regErr = regHit && !regOk;
	wire wrMcrEn = take && busReq.write && mcrSel;
	wire wrMtrEn = take && busReq.write && mtrSel && !stopped;
	wire wrHvcEn = take && busReq.write && hvcSel && !stopped;

	// array access checks, ignored when stopped or disabled
	wire [2:0] blkIdx = busReq.addr[FCPC_BLK_LSB +: 3];
	wire arrLive = arrHit && !regHit && !stopped && !mcr_ff.arrayDisable;
	wire superViol = mcr_ff.supervisorMap[blkIdx] && !busReq.supervisor;
	wire dataViol = mcr_ff.dataMap[blkIdx] && !busReq.dataSpace;
	wire hvBusy = highVoltageStatus;
	wire arrFault = superViol || dataViol;

	// shadow row: supervisor data reads with only low address bits used
	wire shadowRead = mcr_ff.shadowRowSelect && !busReq.write && busReq.supervisor &&
		busReq.dataSpace;
	wire [FCPC_ARR_ADDR_W-1:0] shadowAddr = {{(FCPC_ARR_ADDR_W-FCPC_SHADOW_ADDR_W){1'b0}},
		busReq.addr[FCPC_SHADOW_ADDR_W-1:0]};
	wire [FCPC_ARR_ADDR_W-1:0] arrAddr = shadowRead ? shadowAddr :
		busReq.addr[FCPC_ARR_ADDR_W-1:0];

	// ==========================================
	// configuration register write rules
	assign wrMcr = fcpc_mcr_type'(busReq.wdata);
	assign wrMtr = fcpc_mtr_type'(busReq.wdata);

	wire lockWritable = !mcr_ff.writeLock || (debugMode && mcr_ff.debugUnlock);
	wire mapsOpen = !mcr_ff.writeLock;
	wire emuWritable = mcr_ff.writeLock && mcr_ff.arrayDisable;
	wire shadowWritable = !(!hvcReg.erase && seqOn);

	always_comb
	begin
		nxt_mcr = mcr_ff;
		if (wrMcrEn)
		begin
			if (!seqOn)
			begin
				nxt_mcr.lowPowerStop = wrMcr.lowPowerStop;
				nxt_mcr.arrayDisable = wrMcr.arrayDisable;
			end
			nxt_mcr.debugUnlock = wrMcr.debugUnlock;
			if (emuWritable)
				nxt_mcr.emulationEnable = wrMcr.emulationEnable;
			if (shadowWritable)
				nxt_mcr.shadowRowSelect = wrMcr.shadowRowSelect;
			if (lockWritable)
				nxt_mcr.writeLock = wrMcr.writeLock;
			nxt_mcr.spare24 = wrMcr.spare24;
			if (mapsOpen)
			begin
				nxt_mcr.supervisorMap = wrMcr.supervisorMap;
				nxt_mcr.dataMap = wrMcr.dataMap;
			end
			if (mapsOpen && !seqOn)
				nxt_mcr.protectMap = wrMcr.protectMap;
		end
		nxt_mcr.zero29 = 1'b0;
	end

	// ==========================================
	// test register write rules
	always_comb
	begin
		nxt_mtr = mtr_ff;
		if (wrMtrEn)
		begin
			if (!hvBusy)
			begin
				nxt_mtr.negativeRange = wrMtr.negativeRange;
				nxt_mtr.pulseLevelSelect = wrMtr.pulseLevelSelect;
			end
			if (!seqOn)
				nxt_mtr.gateDrainSelect = wrMtr.gateDrainSelect;
		end
		nxt_mtr.zeroHi = '0;
		nxt_mtr.zero7 = 1'b0;
		nxt_mtr.zero6 = 1'b0;
		nxt_mtr.zeroLo = '0;
	end

	// ==========================================
	// access sequencer
	fcpc_busrsp_type rsp_ff, nxt_rsp;
	fcpc_arrreq_type arr_ff, nxt_arr;
	logic [31:0] regRdata;

	assign regRdata = mcrSel ? 32'(mcr_ff) :
		mtrSel ? 32'(mtr_ff) :
		hvcSel ? 32'(hvcReg) : 32'h00000000;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_rsp = '0;
		nxt_arr = arr_ff;
		case (state_ff)
			FCPC_IDLE:
			begin
				nxt_arr.valid = 1'b0;
				if (take && regHit)
				begin
					nxt_rsp.ack = 1'b1;
					nxt_rsp.transferErr = regErr;
					nxt_rsp.rdataOe = !busReq.write && !regErr;
					nxt_rsp.rdata = (busReq.write || regErr) ? 32'h00000000 : regRdata;
				end
				else if (take && arrLive && (hvBusy || arrFault))
				begin
					nxt_rsp.ack = 1'b1;
					nxt_rsp.transferErr = hvBusy;
					nxt_rsp.dataErr = arrFault && !hvBusy;
				end
				else if (take && arrLive)
				begin
					nxt_arr.valid = 1'b1;
					nxt_arr.write = busReq.write;
					nxt_arr.shadow = shadowRead;
					nxt_arr.emulate = mcr_ff.emulationEnable && !busReq.write;
					nxt_arr.addr = arrAddr;
					nxt_arr.wdata = busReq.wdata;
					nxt_state = FCPC_ISSUE;
				end
			end
			FCPC_ISSUE:
			begin
				nxt_arr.valid = 1'b0;
				nxt_state = FCPC_WAIT;
				if (arrAck)
				begin
					nxt_rsp.ack = 1'b1;
					nxt_rsp.rdataOe = !arr_ff.write && !arr_ff.emulate;
					nxt_rsp.rdata = nxt_rsp.rdataOe ? arrRdata : 32'h00000000;
					nxt_state = FCPC_IDLE;
				end
			end
			FCPC_WAIT:
			begin
				nxt_arr.valid = 1'b0;
				if (arrAck)
				begin
					nxt_rsp.ack = 1'b1;
					nxt_rsp.rdataOe = !arr_ff.write && !arr_ff.emulate;
					nxt_rsp.rdata = nxt_rsp.rdataOe ? arrRdata : 32'h00000000;
					nxt_state = FCPC_IDLE;
				end
			end
			default:
				nxt_state = FCPC_IDLE;
		endcase
	end

	// ==========================================
	// state registers
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			state_ff <= FCPC_IDLE;
			rsp_ff <= '0;
			arr_ff <= '0;
			mtr_ff <= '0;
		end
		else if (clkEn)
		begin
			state_ff <= nxt_state;
			rsp_ff <= nxt_rsp;
			arr_ff <= nxt_arr;
			mtr_ff <= nxt_mtr;
		end
	end

	// strap level is caught on the first enabled edge after release
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			strapDone_ff <= 1'b0;
			mcr_ff <= '{lowPowerStop: 1'b0, debugUnlock: 1'b0, zero29: 1'b0,
				emulationEnable: 1'b0, shadowRowSelect: 1'b0, writeLock: 1'b0,
				arrayDisable: 1'b0, spare24: 1'b0, supervisorMap: FCPC_SUPER_RST,
				dataMap: FCPC_DATA_RST, protectMap: FCPC_PROT_RST};
		end
		else if (clkEn)
		begin
			strapDone_ff <= 1'b1;
			if (!strapDone_ff)
				mcr_ff.arrayDisable <= configStrapPin;
			else
				mcr_ff <= nxt_mcr;
		end
	end

	// ==========================================
	// high-voltage register
	fcpc_hv_ctrl uHvCtrl (
		.clk_sys(clk_sys),
		.rstSyncN(rstSyncN),
		.clkEn(clkEn),
		.wrEn(wrHvcEn),
		.wdata(busReq.wdata),
		.highVoltageStatus(highVoltageStatus),
		.hvcReg(hvcReg),
		.seqStart(seqStart)
	);

	// ==========================================
	// outputs
	wire [7:0] bufMask = mcr_ff.shadowRowSelect ? FCPC_SHADOW_MASK : FCPC_ALL_BLOCKS;

	assign busReady = (state_ff == FCPC_IDLE) && strapDone_ff;
	assign busRsp = rsp_ff;
	assign arrReq = arr_ff;
	assign pageBufEnable = bufMask;
	assign hvBlockEnable = hvcReg.blockSelect & ~mcr_ff.protectMap & bufMask;
	assign lowPowerStop = mcr_ff.lowPowerStop;
	assign pumpLevelValid = mtr_ff.gateDrainSelect && mtr_ff.pulseLevelSelect[2];
	assign pumpLevel = pumpLevelValid ? mtr_ff.pulseLevelSelect[1:0] : 2'h0;
	assign negLowRange = mtr_ff.gateDrainSelect && mtr_ff.negativeRange;

endmodule

// ### test/fcpc_chk.sv
// concurrent checks on the ports of the flash configuration and protection block
module fcpc_chk
	import fcpc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	// processor bus
	input fcpc_busreq_type busReq,
	input wire logic busReady,
	input fcpc_busrsp_type busRsp,
	// array core
	input fcpc_arrreq_type arrReq,
	input wire logic arrAck,
	// engine and pump
	input wire logic highVoltageStatus,
	input wire logic seqStart,
	input fcpc_hvc_type hvcReg,
	input wire logic [7:0] pageBufEnable,
	input wire logic [7:0] hvBlockEnable,
	input wire logic lowPowerStop,
	input wire logic pumpLevelValid,
	input wire logic [1:0] pumpLevel
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====================
	// request decode
	wire logic taken = clkEn && busReq.valid && busReady;
	wire logic arrHit = (busReq.addr & FCPC_ARRAY_MASK) == FCPC_ARRAY_BASE;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// ====================
	// checks
	mcr_served_a:
	assert property (taken && busReq.addr == FCPC_MCR_ADDR |=> busRsp.ack && !busRsp.transferErr)
		else $error("config register access not answered");
	stop_err_a:
	assert property (taken && lowPowerStop && busReq.addr == FCPC_MTR_ADDR
		|=> busRsp.ack && busRsp.transferErr) else $error("no bus error in stop mode");
	stop_noarr_a:
	assert property (taken && lowPowerStop && arrHit |=> !arrReq.valid && !busRsp.ack)
		else $error("array access served in stop mode");
	hv_gate_a:
	assert property ((hvBlockEnable & ~(hvcReg.blockSelect & pageBufEnable)) == 8'h00)
		else $error("voltage on unselected block");
	shadow_buf_a:
	assert property (arrReq.valid && arrReq.shadow |-> pageBufEnable == FCPC_SHADOW_MASK
		&& !arrReq.write) else $error("shadow request outside shadow mode");
	pump_idle_a:
	assert property (!pumpLevelValid |-> pumpLevel == 2'b00) else $error("pump level while idle");
	seq_pulse_a:
	assert property (seqStart |-> hvcReg.sequenceEnable ##1 !seqStart)
		else $error("bad sequence start pulse");
	status_mirror_a:
	assert property (hvcReg.highVoltageStatus == highVoltageStatus)
		else $error("status bit differs from engine");
	emu_nodata_a:
	assert property (arrReq.valid && arrReq.emulate && !arrReq.write |-> ##[1:40]
		(busRsp.ack && !busRsp.rdataOe && busRsp.rdata == 32'h0)) else $error("emulated read drove data");
	arr_ack_a:
	assert property (arrAck |=> busRsp.ack) else $error("array answer not passed on");
endmodule

bind fcpc_top fcpc_chk i_chk (.clk_sys, .rstn, .clkEn, .busReq, .busReady, .busRsp, .arrReq,
	.arrAck, .highVoltageStatus, .seqStart, .hvcReg, .pageBufEnable, .hvBlockEnable,
	.lowPowerStop, .pumpLevelValid, .pumpLevel);

// ### test/fcpc_arr_model.sv
// behavioural array core that answers the block's array requests
module fcpc_arr_model
	import fcpc_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// array request and answer
	input fcpc_arrreq_type arrReq,
	output logic arrAck,
	output logic [31:0] arrRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic slow = 1'b0;
	logic busy = 1'b0;
	logic [1:0] waitCnt = 2'h0;
	logic [31:0] held;
	logic [31:0] noise = 32'h0;
	// ====================
	// answers alternate between the next cycle and four cycles later
	initial arrAck = 1'b0;
	always @(posedge clk_sys)
	begin
		noise <= noise + 32'h13579bdf;
		arrAck <= 1'b0;
		waitCnt <= waitCnt - 2'h1;
		if (busy && waitCnt == 2'h0)
		begin
			arrAck <= 1'b1;
			busy <= 1'b0;
		end
		if (arrReq.valid)
		begin
			held <= {8'h5a, 6'h0, arrReq.shadow, arrReq.addr};
			slow <= !slow;
			busy <= slow;
			arrAck <= !slow;
			waitCnt <= 2'h2;
		end
	end
	// data lines outside an answer keep changing, never the last word
	assign arrRdata = arrAck ? held : noise;
endmodule

// ### test/flash_config_protection_control_tb.sv
// self-checking bench for the flash configuration and protection block
module flash_config_protection_control_tb
	import fcpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys;
	logic rstn;
	logic clkEn;
	logic configStrapPin;
	logic debugMode;
	logic highVoltageStatus;
	fcpc_busreq_type busReq;
	logic busReady;
	fcpc_busrsp_type busRsp;
	fcpc_arrreq_type arrReq;
	logic arrAck;
	logic [31:0] arrRdata;
	logic [7:0] pageBufEnable;
	logic [7:0] hvBlockEnable;
	logic pumpLevelValid;
	logic [1:0] pumpLevel;
	logic negLowRange;
	fcpc_busrsp_type rsp;
	logic got;
	int mismatches;
	int cmp_count;

	fcpc_top i_dut (.clk_sys, .rstn, .clkEn, .configStrapPin, .debugMode, .busReq,
		.busReady, .busRsp, .arrReq, .arrAck, .arrRdata, .highVoltageStatus, .seqStart(),
		.hvcReg(), .pageBufEnable, .hvBlockEnable, .lowPowerStop(), .pumpLevelValid,
		.pumpLevel, .negLowRange);
	fcpc_arr_model i_arr (.clk_sys, .arrReq, .arrAck, .arrRdata);

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial
	begin
		#400us;
		mismatches++;
		report_and_stop();
	end
	// ====================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// request held until ready (at most 20 cycles) plus one edge, then answers collected for eight cycles
	task automatic bus(input logic isWr, sup, dsp, input logic [31:0] a, d);
		busReq = '{1'b1, isWr, sup, dsp, a, d};
		repeat (20)
			if (!busReady)
				@(negedge clk_sys);
		@(negedge clk_sys);
		busReq.valid = 1'b0;
		got = 1'b0;
		repeat (8)
		begin
			if (busRsp.ack && !got)
				rsp = busRsp;
			got |= busRsp.ack;
			@(negedge clk_sys);
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		bus(1'b1, 1'b1, 1'b1, a, d);
	endtask
	task automatic rchk(input logic [31:0] a, exp);
		bus(1'b0, 1'b1, 1'b1, a, 32'h0);
		chk("register read", rsp.rdata, exp);
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ====================
	// scenarios
	task automatic t_reset(input logic strap);
		rstn = 1'b0;
		configStrapPin = strap;
		repeat (20) @(negedge clk_sys);
		rstn = 1'b1;
		rchk(FCPC_MCR_ADDR, {6'h0, strap, 25'h0ff00ff});
		rchk(FCPC_MTR_ADDR, 32'h0);
		rchk(FCPC_HVC_ADDR, 32'h20);
	endtask
	task automatic t_maps();
		bus(1'b0, 1'b1, 1'b1, 32'h100, 32'h0);
		chk("answer while disabled", got, 1'b0);
		wr(FCPC_MCR_ADDR, 32'h110ff000);
		rchk(FCPC_MCR_ADDR, 32'h010ff000);
		bus(1'b0, 1'b0, 1'b1, 32'h104, 32'h0);
		chk("user error", rsp.dataErr, 1'b1);
		bus(1'b0, 1'b0, 1'b1, 32'h10108, 32'h0);
		chk("user read", rsp.rdata, 32'h5a010108);
		bus(1'b0, 1'b1, 1'b0, 32'h1010c, 32'h0);
		chk("program error", rsp.dataErr, 1'b1);
		bus(1'b0, 1'b1, 1'b0, 32'h110, 32'h0);
		chk("program read", rsp.rdata, 32'h5a000110);
	endtask
	task automatic t_lock();
		wr(FCPC_MCR_ADDR, 32'h0600000f);
		rchk(FCPC_MCR_ADDR, 32'h0600000f);
		wr(FCPC_MCR_ADDR, 32'h16ffffff);
		chk("locked write error", rsp.transferErr, 1'b0);
		rchk(FCPC_MCR_ADDR, 32'h1600000f);
		wr(FCPC_MCR_ADDR, 32'h12000000);
		rchk(FCPC_MCR_ADDR, 32'h1600000f);
		wr(FCPC_MCR_ADDR, 32'h14000000);
		bus(1'b0, 1'b1, 1'b1, 32'h4040, 32'h0);
		chk("emulated data", rsp.rdata, 32'h0);
		chk("emulated answer", {got, rsp.rdataOe}, 2'b10);
		debugMode = 1'b1;
		wr(FCPC_MCR_ADDR, 32'h54000000);
		wr(FCPC_MCR_ADDR, 32'h46000000);
		wr(FCPC_MCR_ADDR, 32'h40000000);
		rchk(FCPC_MCR_ADDR, 32'h4000000f);
		debugMode = 1'b0;
	endtask
	task automatic t_stop();
		wr(FCPC_MCR_ADDR, 32'hd000000f);
		rchk(FCPC_MCR_ADDR, 32'hc000000f);
		bus(1'b0, 1'b1, 1'b1, FCPC_MTR_ADDR, 32'h0);
		chk("stop bus error", rsp.transferErr, 1'b1);
		bus(1'b0, 1'b1, 1'b1, 32'hc000, 32'h0);
		chk("answer in stop", got, 1'b0);
		wr(FCPC_MCR_ADDR, 32'h5000000f);
	endtask
	task automatic t_shadow();
		wr(FCPC_MCR_ADDR, 32'h5800000f);
		chk("page buffers", pageBufEnable, 8'h01);
		bus(1'b0, 1'b1, 1'b1, 32'h1c044, 32'h0);
		chk("shadow read", rsp.rdata, 32'h5a020044);
		wr(FCPC_HVC_ADDR, 32'h2);
		wr(FCPC_MCR_ADDR, 32'h52000000);
		rchk(FCPC_MCR_ADDR, 32'h4800000f);
		wr(FCPC_HVC_ADDR, 32'h0);
		wr(FCPC_HVC_ADDR, 32'hff00);
		chk("shadow voltage", hvBlockEnable, 8'h00);
		wr(FCPC_MCR_ADDR, 32'h5000000f);
		chk("block voltage", hvBlockEnable, 8'hf0);
	endtask
	task automatic t_pump();
		highVoltageStatus = 1'b1;
		rchk(FCPC_HVC_ADDR, 32'h8000ff20);
		wr(FCPC_MTR_ADDR, 32'h820);
		rchk(FCPC_MTR_ADDR, 32'h20);
		highVoltageStatus = 1'b0;
		wr(FCPC_MTR_ADDR, 32'hffffffff);
		chk("test write error", rsp.transferErr, 1'b0);
		rchk(FCPC_MTR_ADDR, 32'hf20);
		chk("low range", negLowRange, 1'b1);
		for (int p = 0; p < 8; p++)
		begin
			wr(FCPC_MTR_ADDR, {21'h0, p[2:0], 8'h20});
			chk("pump valid", pumpLevelValid, p[2]);
			chk("pump level", pumpLevel, p[2] ? p[1:0] : 2'b00);
		end
		wr(FCPC_MTR_ADDR, 32'h800);
		chk("drain range", negLowRange, 1'b0);
	endtask
	// enable held low: a write must neither be answered nor land
	task automatic t_freeze();
		clkEn = 1'b0;
		wr(FCPC_MCR_ADDR, 32'h4100000f);
		chk("frozen answer", got, 1'b0);
		clkEn = 1'b1;
		rchk(FCPC_MCR_ADDR, 32'h4000000f);
	endtask
	initial
	begin
		busReq = '0;
		clkEn = 1'b1;
		rstn = 1'b0;
		configStrapPin = 1'b1;
		debugMode = 1'b0;
		highVoltageStatus = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		@(negedge clk_sys);
		t_reset(1'b1);
		t_maps();
		t_lock();
		t_stop();
		t_shadow();
		t_pump();
		t_freeze();
		t_reset(1'b0);
		report_and_stop();
	end
endmodule
